// ### core/rfpc_pkg.sv
/*
  Constants, register layout and carrier types of the receive FIFO pause flow control block.
  Assumes a 10 MHz core clock and a gigabit link whose bit time is 1 ns.
*/
// Operation
// - Lower fill level is read/write bits 15:0 of the watermark register, reset 500h.
// - Upper fill level is read/write bits 31:16 of the watermark register, reset 3B00h.
// - Both levels compare against receive FIFO DWORD entries in use.
// - Reaching the upper level sends a PAUSE frame with time FFFFh quanta.
// - Above the lower level, maximum PAUSE frames repeat slightly before expiry.
// - Falling to the lower level after pausing sends one zero-time PAUSE.
package rfpc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] WMARK_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [15:0] RELEASE_RESET = 16'h0500;
  localparam logic [15:0] ASSERT_RESET = 16'h3B00;
  localparam int RELEASE_LSB = 0;
  localparam int ASSERT_LSB = 16;
  localparam int STAT_PAUSED_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_LEVEL_LSB = 16;
  localparam logic [15:0] PAUSE_MAX = 16'hFFFF;
  localparam logic [15:0] PAUSE_ZERO = 16'h0000;
  // One quantum is 512 bit times of 1 ns; refresh is issued 1/16 early.
  localparam longint QUANTUM_NS = 512;
  localparam longint CLOCK_NS = 100;
  localparam longint PAUSE_SPAN_NS = 64'd65535 * QUANTUM_NS;
  localparam longint REFRESH_NS = PAUSE_SPAN_NS - (PAUSE_SPAN_NS / 16);
  localparam int REFRESH_CYCLES = int'(REFRESH_NS / CLOCK_NS);
  localparam int TIMER_W = 24;
  localparam logic [47:0] CTRL_DEST = 48'h0180_C200_0001;
  localparam logic [15:0] CTRL_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [5:0] FRAME_BYTES = 6'h3C;
  localparam logic [5:0] IDX_SRC = 6'h06;
  localparam logic [5:0] IDX_TYPE = 6'h0C;
  localparam logic [5:0] IDX_OPC = 6'h0E;
  localparam logic [5:0] IDX_TIME = 6'h10;
  localparam logic [5:0] IDX_PAD = 6'h12;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } rfpc_tx_t;

  typedef struct packed {
    logic [15:0] assertLevel;
    logic [15:0] releaseLevel;
  } rfpc_wmark_t;
endpackage

// ### core/rfpc_frame_gen.sv
/*
  Byte serialiser for one PAUSE control frame, without preamble and FCS.
  Assumes the MAC transmit path appends the FCS and drains bytes on txReady.
*/
`timescale 1ns/1ns
module rfpc_frame_gen (
  input wire logic clock, // Core clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic start, // Begin a frame; ignored while busy.
  input wire logic [15:0] pauseTime, // Pause quanta for this frame.
  input wire logic [47:0] srcAddr, // Station address placed as source.
  input wire logic txReady, // MAC accepts the presented byte.
  output rfpc_pkg::rfpc_tx_t tx, // Byte stream towards the MAC.
  output logic busy // A frame is in progress.
);
  logic [5:0] idx_r, idx_nxt;
  logic [15:0] time_r, time_nxt;
  rfpc_pkg::rfpc_tx_t tx_r, tx_nxt;
  logic busy_r, busy_nxt;

  function automatic logic [7:0] frameByte(input logic [5:0] i, input logic [47:0] sa,
                                           input logic [15:0] pt);
    logic [7:0] b;
    b = 8'h00;
    if (i < rfpc_pkg::IDX_SRC) begin
      b = rfpc_pkg::CTRL_DEST[8*(5-i) +: 8];
    end else if (i < rfpc_pkg::IDX_TYPE) begin
      b = sa[8*(11-i) +: 8];
    end else if (i < rfpc_pkg::IDX_OPC) begin
      b = rfpc_pkg::CTRL_TYPE[8*(13-i) +: 8];
    end else if (i < rfpc_pkg::IDX_TIME) begin
      b = rfpc_pkg::PAUSE_OPCODE[8*(15-i) +: 8];
    end else if (i < rfpc_pkg::IDX_PAD) begin
      b = pt[8*(17-i) +: 8];
    end
    return b;
  endfunction

  always_comb begin
    idx_nxt = idx_r;
    time_nxt = time_r;
    tx_nxt = tx_r;
    busy_nxt = busy_r;
    if (!busy_r) begin
      if (start) begin
        busy_nxt = 1'b1;
        time_nxt = pauseTime;
        idx_nxt = 6'h01;
        tx_nxt.valid = 1'b1;
        tx_nxt.last = 1'b0;
        tx_nxt.data = frameByte(6'h00, srcAddr, pauseTime);
      end
    end else if (txReady) begin
      if (tx_r.last) begin
        busy_nxt = 1'b0;
        tx_nxt.valid = 1'b0;
        tx_nxt.last = 1'b0;
      end else begin
        tx_nxt.data = frameByte(idx_r, srcAddr, time_r);
        tx_nxt.last = (idx_r == rfpc_pkg::FRAME_BYTES - 6'h01);
        idx_nxt = idx_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      idx_r <= 6'h00;
      time_r <= 16'h0000;
      tx_r <= '0;
      busy_r <= 1'b0;
    end else begin
      idx_r <= idx_nxt;
      time_r <= time_nxt;
      tx_r <= tx_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign tx = tx_r;
  assign busy = busy_r;
endmodule

// ### core/rfpc_flow_ctrl.sv
/*
  Receive FIFO watermark flow control: registers, pause state and frame requests.
  Assumes rxFifoUsed is a synchronous DWORD occupancy count and software uses
  the plain strobe register port with read data one cycle after the strobe.
*/
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module rfpc_flow_ctrl #(
  parameter int REFRESH_CYCLES = rfpc_pkg::REFRESH_CYCLES
) (
  input wire logic clock, // Core clock, 10 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [7:0] regAddr, // Register byte address.
  input wire logic [31:0] regWrData, // Register write data.
  input wire logic regWrStb, // Write strobe.
  input wire logic regRdStb, // Read strobe.
  output logic [31:0] regRdData, // Read data, valid the cycle after regRdStb.
  input wire logic [15:0] rxFifoUsed, // DWORDs in use in the receive FIFO.
  input wire logic [47:0] stationAddr, // Source address for PAUSE frames.
  input wire logic txReady, // MAC takes the presented byte.
  output rfpc_pkg::rfpc_tx_t tx, // PAUSE frame byte stream.
  output logic pauseActive // Partner is being held paused.
);
  typedef enum logic [0:0] {RFPC_IDLE, RFPC_HOLD} rfpc_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.
  rfpc_pkg::rfpc_wmark_t wmark_r, wmark_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic genBusy;
  rfpc_state_t state_r, state_nxt;

  always_comb begin
    wmark_nxt = wmark_r;
    rdData_nxt = 32'h0000_0000;
    if (regWrStb && regAddr == rfpc_pkg::WMARK_ADDR) begin
      wmark_nxt.releaseLevel = regWrData[rfpc_pkg::RELEASE_LSB +: 16];
      wmark_nxt.assertLevel = regWrData[rfpc_pkg::ASSERT_LSB +: 16];
    end
    if (regRdStb) begin
      unique case (regAddr)
        rfpc_pkg::WMARK_ADDR: begin
          rdData_nxt[rfpc_pkg::RELEASE_LSB +: 16] = wmark_r.releaseLevel;
          rdData_nxt[rfpc_pkg::ASSERT_LSB +: 16] = wmark_r.assertLevel;
        end
        rfpc_pkg::STATUS_ADDR: begin
          rdData_nxt[rfpc_pkg::STAT_PAUSED_BIT] = (state_r == RFPC_HOLD);
          rdData_nxt[rfpc_pkg::STAT_BUSY_BIT] = genBusy;
          rdData_nxt[rfpc_pkg::STAT_LEVEL_LSB +: 16] = rxFifoUsed;
        end
        default: begin
          rdData_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wmark_r.releaseLevel <= rfpc_pkg::RELEASE_RESET;
      wmark_r.assertLevel <= rfpc_pkg::ASSERT_RESET;
      rdData_r <= 32'h0000_0000;
    end else begin
      wmark_r <= wmark_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Pause state, refresh timer and pending frame requests.
  logic [rfpc_pkg::TIMER_W-1:0] timer_r, timer_nxt;
  logic pendMax_r, pendMax_nxt;
  logic pendZero_r, pendZero_nxt;
  logic atAssert, atRelease, genStart;
  logic [15:0] genTime;

  assign atAssert = (rxFifoUsed >= wmark_r.assertLevel);
  assign atRelease = (rxFifoUsed <= wmark_r.releaseLevel);
  assign genStart = !genBusy && (pendMax_r || pendZero_r);
  // A zero-time request is the newer state whenever both are pending.
  assign genTime = pendZero_r ? rfpc_pkg::PAUSE_ZERO : rfpc_pkg::PAUSE_MAX;

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    pendMax_nxt = pendMax_r;
    pendZero_nxt = pendZero_r;
    if (genStart) begin
      pendMax_nxt = 1'b0;
      pendZero_nxt = 1'b0;
    end
    if (genStart && !pendZero_r) begin
      timer_nxt = rfpc_pkg::TIMER_W'(REFRESH_CYCLES - 1);
    end else if (timer_r != '0) begin
      timer_nxt = timer_r - 1'b1;
    end
    unique case (state_r)
      RFPC_IDLE: begin
        if (atAssert) begin
          state_nxt = RFPC_HOLD;
          pendMax_nxt = 1'b1;
          pendZero_nxt = 1'b0;
        end
      end
      RFPC_HOLD: begin
        if (atRelease) begin
          state_nxt = RFPC_IDLE;
          pendZero_nxt = 1'b1;
          pendMax_nxt = 1'b0;
        end else if (timer_r == '0 && !pendMax_r && !genBusy) begin
          pendMax_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= RFPC_IDLE;
      timer_r <= '0;
      pendMax_r <= 1'b0;
      pendZero_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      pendMax_r <= pendMax_nxt;
      pendZero_r <= pendZero_nxt;
    end
  end

  assign pauseActive = (state_r == RFPC_HOLD);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame serialiser.
  rfpc_frame_gen frameGen (
    .clock(clock),
    .srst(srst),
    .start(genStart),
    .pauseTime(genTime),
    .srcAddr(stationAddr),
    .txReady(txReady),
    .tx(tx),
    .busy(genBusy)
  );
endmodule

// ### testbench/rfpc_flow_ctrl_assertions.sv
/* Port assertions for the flow control block.
   Assumes binding to rfpc_flow_ctrl from tb_top. */
`timescale 1ns/1ns
module rfpc_flow_ctrl_assertions (
  input wire logic clock, // Core clock.
  input wire logic srst, // Reset.
  input wire logic [7:0] regAddr, // Address.
  input wire logic [31:0] regWrData, // Write data.
  input wire logic regWrStb, // Write strobe.
  input wire logic regRdStb, // Read strobe.
  input wire logic [31:0] regRdData, // Read data.
  input wire logic [15:0] rxFifoUsed, // FIFO fill.
  input wire logic txReady, // Byte taken.
  input wire rfpc_pkg::rfpc_tx_t tx, // Byte stream.
  input wire logic pauseActive // Hold state.
);
  logic [31:0] lvl_r;
  logic [31:0] lvl_nxt;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Shadow of the watermark register, kept from observed writes.
  always_comb lvl_nxt = (regWrStb && regAddr == 8'h00) ? regWrData : lvl_r;
  always_ff @(posedge clock) lvl_r <= srst ? 32'h3B00_0500 : lvl_nxt;
  property p_enter; !pauseActive && rxFifoUsed >= lvl_r[31:16] |=> pauseActive; endproperty
  a_enter: assert property (p_enter) else $error("hold not entered");
  property p_stay; pauseActive && rxFifoUsed > lvl_r[15:0] |=> pauseActive; endproperty
  a_stay: assert property (p_stay) else $error("hold left early");
  property p_exit; pauseActive && rxFifoUsed <= lvl_r[15:0] |=> !pauseActive; endproperty
  a_exit: assert property (p_exit) else $error("hold not left");
  property p_rd; regRdStb && regAddr == 8'h00 |=> regRdData == $past(lvl_r); endproperty
  a_rd: assert property (p_rd) else $error("level readback");
  property p_rdz; !regRdStb |=> regRdData == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data not idle");
  property p_kick; $rose(pauseActive) |-> ##[1:130] (tx.valid && tx.data == 8'h01); endproperty
  a_kick: assert property (p_kick) else $error("no frame after hold");
  property p_stand; tx.valid && !txReady |=> tx.valid && $stable(tx.data); endproperty
  a_stand: assert property (p_stand) else $error("byte dropped");
  property p_first; $rose(tx.valid) |-> tx.data == 8'h01; endproperty
  a_first: assert property (p_first) else $error("bad first byte");
endmodule

// ### testbench/rfpc_mac_model.sv
/* Far-side MAC transmit path taking PAUSE frame bytes.
   Assumes one byte is taken per edge with txReady high. */
`timescale 1ns/1ns
module rfpc_mac_model (
  input wire logic clock, // Core clock.
  input wire rfpc_pkg::rfpc_tx_t tx, // Bytes in.
  input wire logic [47:0] stationAddr, // Source.
  input wire logic slow, // Random stalls.
  output logic txReady = 1'b0, // Byte taken.
  output logic [15:0] lastTime, // Last pause time.
  output int frames = 0, // Frames seen.
  output int bad = 0 // Malformed frames.
);
  logic [7:0] q[$];
  logic [127:0] hdr;
  int n;
  always @(posedge clock) begin
    txReady <= slow ? 1'($urandom % 2) : 1'b1;
    if (tx.valid && txReady) begin
      q.push_back(tx.data);
      if (tx.last) begin
        hdr = {48'h0180_C200_0001, stationAddr, 32'h8808_0001};
        n = 0;
        foreach (q[i]) begin
          if (!(i inside {16, 17}) && q[i] !== (i < 16 ? hdr[127-8*i -: 8] : 8'h00)) n++;
        end
        if (q.size() != 60 || n != 0) bad <= bad + 1;
        lastTime <= {q[16], q[17]};
        frames <= frames + 1;
        q = {};
      end
    end
  end
endmodule

// ### testbench/tb_top.sv
/* Top testbench of the receive FIFO pause flow control block.
   Assumes the design, MAC model and checker are compiled before it. */
`timescale 1ns/1ns
module tb_top;
  localparam int RC = 200;
  logic clock = 0, srst = 1, regWrStb = 0, regRdStb = 0, slow = 1, mHold = 0, txReady, pauseActive;
  logic [7:0] regAddr = 0;
  logic [31:0] regWrData = 0, regRdData, d;
  logic [15:0] rxFifoUsed = 0, lastTime, expq[$];
  logic [47:0] stationAddr = 48'h02AB_CDEF_1234;
  rfpc_pkg::rfpc_tx_t tx;
  int errors = 0, n_checks = 0, frames, bad, lo = 16'h0500, hi = 16'h3B00, lastAt = 0;
  always #50 clock = ~clock;
  rfpc_flow_ctrl #(.REFRESH_CYCLES(RC)) dut (.clock(clock), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .rxFifoUsed(rxFifoUsed), .stationAddr(stationAddr), .txReady(txReady), .tx(tx),
    .pauseActive(pauseActive));
  rfpc_mac_model mac (.clock(clock), .tx(tx), .stationAddr(stationAddr), .slow(slow),
    .txReady(txReady), .lastTime(lastTime), .frames(frames), .bad(bad));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge clock) regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock) regRdStb <= 1'b0;
    #1 check(regRdData, v);
    @(posedge clock);
  endtask
  task automatic waitf(input int n);
    for (int i = 0; i < 1000 && frames < n; i++) @(posedge clock);
    if (frames < n) begin
      errors++;
      close_out();
    end
  endtask
  // Reference model of the hold state; it queues the pause time each change must send.
  // Levels follow observed writes, so a new level acts one edge after its strobe.
  always @(posedge clock) begin
    if (srst) begin
      mHold <= 1'b0;
      lo <= 16'h0500;
      hi <= 16'h3B00;
    end else begin
      if (regWrStb && regAddr == 8'h00) begin
        lo <= regWrData[15:0];
        hi <= regWrData[31:16];
      end
      if (!mHold && rxFifoUsed >= hi) begin
        mHold <= 1'b1;
        expq.push_back(16'hFFFF);
      end else if (mHold && rxFifoUsed <= lo) begin
        mHold <= 1'b0;
        expq.push_back(16'h0000);
      end
    end
  end
  always @(frames) if (frames > 0) begin
    if (expq.size() == 0) begin
      check({mHold, lastTime}, 17'h1_FFFF);
      check(32'(int'($time / 100) - lastAt inside {[RC - 2:RC + 4]}), 32'h0000_0001);
    end else check(lastTime, expq.pop_front());
    check(bad, 32'h0000_0000);
    lastAt = int'($time / 100);
  end
  initial begin
    void'($urandom(32'h5756));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 32'h3B00_0500);
    rd(8'h10, 32'h0000_0000);
    wr(8'h10, 32'h0001_0001);
    rd(8'h00, 32'h3B00_0500);
    d = $urandom | 32'h8000_0000;
    wr(8'h00, d);
    rd(8'h00, d);
    wr(8'h00, 32'h0040_0010);
    rxFifoUsed <= 16'h003F;
    repeat (50) @(posedge clock);
    check({frames[7:0], pauseActive}, 9'h000);
    slow <= 1'b0;
    rxFifoUsed <= 16'h0040;
    repeat (3) @(posedge clock);
    rd(8'h04, 32'h0040_0003);
    waitf(1);
    rxFifoUsed <= 16'h0011;
    waitf(3);
    check(pauseActive, 1'b1);
    slow <= 1'b1;
    rxFifoUsed <= 16'h0010;
    waitf(4);
    check(pauseActive, 1'b0);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 32'h3B00_0500);
    check(pauseActive, 1'b0);
    close_out();
  end
endmodule
bind rfpc_flow_ctrl rfpc_flow_ctrl_assertions chk (.clock(clock), .srst(srst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .rxFifoUsed(rxFifoUsed), .txReady(txReady), .tx(tx), .pauseActive(pauseActive));
